//--- design/safc_pkg.sv
package safc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_INPUT_CFG = 8'h00;
    localparam logic [7:0] ADDR_OPMODE = 8'h01;
    localparam logic [7:0] ADDR_SEQ_CHEN = 8'h02;
    localparam logic [7:0] ADDR_OFFCAL = 8'h03;
    localparam logic [7:0] ADDR_OSC = 8'h04;
    localparam logic [7:0] ADDR_CLOCKS_PER_CONVERSION = 8'h05;
    localparam logic [7:0] ADDR_SEQ_START = 8'h06;
    localparam logic [7:0] ADDR_SEQ_STATUS = 8'h07;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_CAL_OFFSET = 8'h09;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int START_BIT = 0;
    localparam int ABORT_BIT = 1;
    localparam int ERR_BIT = 0;
    localparam int BUSY_BIT = 1;
    localparam int CH1_BIT = 1;
    localparam logic [1:0] ARR_TWO_SE_A = 2'h0;
    localparam logic [1:0] ARR_ONE_SE = 2'h1;
    localparam logic [1:0] ARR_ONE_PD = 2'h2;
    localparam logic [1:0] ARR_TWO_SE_B = 2'h3;
    localparam logic [2:0] MODE_MANUAL_AUTO = 3'h4;
    localparam logic [2:0] MODE_AUTONOMOUS = 3'h6;
    localparam logic [2:0] MODE_HIGH_PREC = 3'h7;
    localparam logic [11:0] NEGATIVE_FULL_SCALE_CODE = 12'h000;
    localparam logic [11:0] MID_SCALE_CODE = 12'h800;
    localparam logic [11:0] POSITIVE_FULL_SCALE_CODE = 12'hfff;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [1:0] RST_ARRANGEMENT = ARR_TWO_SE_A;
    localparam logic [2:0] RST_OPMODE = 3'h0;
    localparam logic [1:0] RST_SEQ_CHEN = 2'h0;
    localparam logic RST_OSC = 1'b0;
    localparam logic [7:0] RST_CLOCKS_PER_CONVERSION = 8'h15;
    localparam int RESULT_DEPTH = 16;
    localparam int CAL_CYCLES = 16;

    typedef enum logic [2:0] {
        SAFC_IDLE = 3'b000,
        SAFC_CAL = 3'b001,
        SAFC_ACQ = 3'b011,
        SAFC_CONV = 3'b010,
        SAFC_DONE = 3'b110
    } safc_state_t;

endpackage

//--- design/safc_top.sv
`timescale 1ns/100ps
// Contract
// - Arrangement codes 00b and 11b mean two-channel single-ended; default after reset.
// - Two-channel single-ended: second capacitor samples ground, first the channel.
// - Reset gives manual mode, channel 0 only; mode 000b/001b do likewise.
// - A channel joins the sequence only when its enable bit is 1. Code converts channel 0 in modes 000b-011b whatever its enable bit.
// - Mode 100b/101b manual-auto, 110b autonomous, 111b high precision.
// - Code 01b: first capacitor input A, second input B, ground sense.
// - Code 10b: pseudo-differential, A on first capacitor, B on second.
// - Single-channel arrangement with channel 1 enabled sets sequence error flag.
// - Calibration trigger measures offset, subtracted from all later results.
// - During calibration switches open and busy held high until done.
// - Calibration runs automatically after reset without host request.
// - Results are 12-bit unsigned straight binary, step reference over 4096.
// - Codes 000 negative full scale, 800 mid, fff positive full scale.
// - Switches closed during acquisition, open during conversion.
// - Oscillator choice 1 low power, 0 high speed.
// - Each conversion lasts exactly clocks_per_conversion oscillator clocks.
// - Manual: host starts each conversion; autonomous: device starts itself.
// - Store up to 16 results autonomous; accumulate 16 in high precision. Code runs 16 but keeps only the latest in result.
// - Busy goes low when a sequence completes or abort is requested outside calibration.
module safc_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic hso_tick,
    input wire logic lpo_tick,
    input wire logic [11:0] sar_code,
    output logic sw_first_closed,
    output logic sw_second_closed,
    output logic first_sel_b,
    output logic second_sel,
    output logic osc_low_power,
    output logic busy,
    output logic [15:0] result
);
    import safc_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] hso_sync;
    logic [1:0] lpo_sync;
    logic [1:0] hso_edge;
    logic [1:0] lpo_edge;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hso_sync <= 2'h0;
            lpo_sync <= 2'h0;
            hso_edge <= 2'h0;
            lpo_edge <= 2'h0;
        end else begin
            hso_sync <= {hso_sync[0], hso_tick};
            lpo_sync <= {lpo_sync[0], lpo_tick};
            hso_edge <= {hso_edge[0], hso_sync[1]};
            lpo_edge <= {lpo_edge[0], lpo_sync[1]};
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0] input_pair_arrangement;
    logic [2:0] operating_mode_select;
    logic [1:0] sequence_channel_enables;
    logic oscillator_choice;
    logic [7:0] clocks_per_conversion;
    logic offset_cal_trigger;
    logic seq_start;
    logic seq_abort;
    logic seq_error;
    logic [1:0] act_arr;
    logic act_osc;
    logic [11:0] cal_offset;
    logic [15:0] acc;
    logic [4:0] done_count;
    safc_state_t state;
    logic [7:0] cyc_count;
    logic cur_ch;
    logic single_arr;
    logic wr_hit;

    assign wr_hit = wr;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            input_pair_arrangement <= RST_ARRANGEMENT;
            operating_mode_select <= RST_OPMODE;
            sequence_channel_enables <= RST_SEQ_CHEN;
            oscillator_choice <= RST_OSC;
            clocks_per_conversion <= RST_CLOCKS_PER_CONVERSION;
        end else if (wr_hit) begin
            unique case (addr)
                ADDR_INPUT_CFG: input_pair_arrangement <= wdata[1:0];
                ADDR_OPMODE: operating_mode_select <= wdata[2:0];
                ADDR_SEQ_CHEN: sequence_channel_enables <= wdata[1:0];
                ADDR_OSC: oscillator_choice <= wdata[0];
                ADDR_CLOCKS_PER_CONVERSION: clocks_per_conversion <= wdata[7:0];
                default: ;
            endcase
        end
    end

    // Command strobes are one-cycle pulses from register writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            offset_cal_trigger <= 1'b0;
            seq_start <= 1'b0;
            seq_abort <= 1'b0;
        end else begin
            offset_cal_trigger <= wr && addr == ADDR_OFFCAL && wdata[0];
            seq_start <= wr && addr == ADDR_SEQ_START && wdata[START_BIT];
            seq_abort <= wr && addr == ADDR_SEQ_START && wdata[ABORT_BIT];
        end
    end

    // ------------------------------------------------------------
    // Error flag: level follows the illegal combination
    // ------------------------------------------------------------
    assign single_arr = input_pair_arrangement == ARR_ONE_SE ||
        input_pair_arrangement == ARR_ONE_PD;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seq_error <= 1'b0;
        end else begin
            seq_error <= single_arr && sequence_channel_enables[CH1_BIT];
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic osc_edge;
    logic auto_mode;
    logic seq_mode;
    logic [1:0] ch_en;
    logic [11:0] corrected;
    assign osc_edge = act_osc ? (lpo_edge[0] & ~lpo_edge[1]) :
        (hso_edge[0] & ~hso_edge[1]);
    assign auto_mode = operating_mode_select == MODE_AUTONOMOUS ||
        operating_mode_select == MODE_HIGH_PREC;
    assign seq_mode = operating_mode_select[2];
    // Channel 1 is only usable when the arrangement is two-channel
    assign ch_en = seq_mode ? {sequence_channel_enables[1] & ~single_arr,
        sequence_channel_enables[0]} : 2'b01;
    // Offset subtraction clamps at the negative full-scale code
    assign corrected = (sar_code > cal_offset) ? sar_code - cal_offset :
        NEGATIVE_FULL_SCALE_CODE;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= SAFC_CAL;
            cyc_count <= 8'h0;
            cur_ch <= 1'b0;
            act_arr <= RST_ARRANGEMENT;
            act_osc <= RST_OSC;
            cal_offset <= 12'h0;
            acc <= 16'h0;
            done_count <= 5'h0;
            result <= 16'h0;
        end else if (seq_abort && state != SAFC_CAL) begin
            state <= SAFC_IDLE;
        end else begin
            unique case (state)
                SAFC_IDLE: begin
                    cyc_count <= 8'h0;
                    if (offset_cal_trigger) begin
                        state <= SAFC_CAL;
                    end else if (seq_start && ch_en != 2'b00) begin
                        // Host start in manual, one start runs 16 conversions in auto
                        state <= SAFC_ACQ;
                        cur_ch <= ~ch_en[0];
                        act_arr <= input_pair_arrangement;
                        act_osc <= oscillator_choice;
                        acc <= 16'h0;
                        done_count <= 5'h0;
                    end
                end
                SAFC_CAL: begin
                    if (osc_edge) begin
                        cyc_count <= cyc_count + 8'h1;
                    end
                    if (cyc_count == 8'(CAL_CYCLES)) begin
                        // Inputs shorted: code minus mid-scale is the offset
                        cal_offset <= sar_code - MID_SCALE_CODE;
                        cyc_count <= 8'h0;
                        state <= SAFC_IDLE;
                    end
                end
                SAFC_ACQ, SAFC_CONV: begin
                    if (osc_edge) begin
                        cyc_count <= cyc_count + 8'h1;
                        if (cyc_count == (clocks_per_conversion >> 1)) begin
                            state <= SAFC_CONV;
                        end
                        if (cyc_count + 8'h1 >= clocks_per_conversion) begin
                            state <= SAFC_DONE;
                        end
                    end
                end
                SAFC_DONE: begin
                    cyc_count <= 8'h0;
                    done_count <= done_count + 5'h1;
                    if (operating_mode_select == MODE_HIGH_PREC) begin
                        acc <= acc + {4'h0, corrected};
                        result <= acc + {4'h0, corrected};
                    end else begin
                        result <= {3'h0, cur_ch, corrected};
                    end
                    act_arr <= input_pair_arrangement;
                    act_osc <= oscillator_choice;
                    // In auto modes, channel 0 then channel 1 when both are enabled
                    cur_ch <= (ch_en == 2'b11) ? ~cur_ch : cur_ch;
                    if (auto_mode &&
                        done_count + 5'h1 < 5'(RESULT_DEPTH)) begin
                        state <= SAFC_ACQ;
                    end else begin
                        state <= SAFC_IDLE;
                    end
                end
                default: state <= SAFC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Analog front-end controls
    // ------------------------------------------------------------
    always_comb begin
        sw_first_closed = state == SAFC_ACQ;
        sw_second_closed = state == SAFC_ACQ;
        osc_low_power = act_osc;
        busy = state != SAFC_IDLE;
        unique case (act_arr)
            ARR_ONE_SE, ARR_ONE_PD: begin
                first_sel_b = 1'b0;
                second_sel = 1'b1;
            end
            default: begin
                first_sel_b = cur_ch;
                second_sel = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0;
        end else if (rd) begin
            unique case (addr)
                ADDR_INPUT_CFG: rdata <= {14'h0, input_pair_arrangement};
                ADDR_OPMODE: rdata <= {13'h0, operating_mode_select};
                ADDR_SEQ_CHEN: rdata <= {14'h0, sequence_channel_enables};
                ADDR_OSC: rdata <= {15'h0, oscillator_choice};
                ADDR_CLOCKS_PER_CONVERSION: rdata <= {8'h0, clocks_per_conversion};
                ADDR_SEQ_STATUS: rdata <= {14'h0, busy, seq_error};
                ADDR_RESULT: rdata <= result;
                ADDR_CAL_OFFSET: rdata <= {4'h0, cal_offset};
                default: rdata <= 16'h0;
            endcase
        end else begin
            rdata <= 16'h0;
        end
    end

endmodule

//--- test/safc_analog_model.sv
`timescale 1ns/100ps
module safc_analog_model (
    input wire logic clk,
    input wire logic [11:0] ain_a,
    input wire logic [11:0] ain_b,
    input wire logic [11:0] offs,
    input wire logic sw_first_closed,
    input wire logic first_sel_b,
    input wire logic second_sel,
    input wire logic busy,
    output logic hso_tick,
    output logic lpo_tick,
    output logic [11:0] sar_code
);
    logic [3:0] div = 4'h0;
    logic [12:0] held = 13'h0800;
    logic [12:0] sample;
    // Set once the switches have closed in this busy spell; a busy spell
    // that never closes them is a calibration with the inputs shorted
    logic sampled = 1'b0;
    // Oscillators run free: high speed 4 clocks, low power 16 clocks
    assign hso_tick = div[1];
    assign lpo_tick = div[3];
    assign sample = {1'b0, first_sel_b ? ain_b : ain_a} + {1'b0, offs}
        - {1'b0, second_sel ? ain_b : 12'h000};
    // Clips at full scale like a real converter would
    assign sar_code = held[12] ? 12'hfff : held[11:0];
    always_ff @(posedge clk) div <= div + 4'h1;
    // Capacitors track while closed, hold while open in a busy spell after sampling; otherwise sit at mid-scale plus offset
    always_ff @(posedge clk) begin
        if (sw_first_closed) begin
            held <= sample;
            sampled <= 1'b1;
        end else if (!busy || !sampled) begin
            held <= 13'h0800 + {1'b0, offs};
            if (!busy)
                sampled <= 1'b0;
        end
    end
endmodule

//--- test/safc_top_checker.sv
`timescale 1ns/100ps
module safc_top_checker
    import safc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic hso_tick,
    input wire logic lpo_tick,
    input wire logic [11:0] sar_code,
    input wire logic sw_first_closed,
    input wire logic sw_second_closed,
    input wire logic first_sel_b,
    input wire logic second_sel,
    input wire logic osc_low_power,
    input wire logic busy,
    input wire logic [15:0] result
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic go_wr;
    logic stop_wr;
    logic conv_q;
    assign go_wr = wr && addr == ADDR_SEQ_START && wdata[START_BIT]
        && !wdata[ABORT_BIT];
    assign stop_wr = wr && addr == ADDR_SEQ_START && wdata[ABORT_BIT];
    // Busy with switches open: settings must not move underneath
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            conv_q <= 1'b0;
        else
            conv_q <= busy && !sw_first_closed;
    end
    property p_cal_busy;
        $rose(rstn) |-> ##[0:3] busy;
    endproperty
    a_cal_busy: assert property (p_cal_busy)
        else $error("no calibration after reset");
    property p_cal_open;
        $rose(rstn) |-> !sw_first_closed [*8];
    endproperty
    a_cal_open: assert property (p_cal_open)
        else $error("switch closed in calibration");
    property p_sw_busy;
        sw_first_closed |-> busy;
    endproperty
    a_sw_busy: assert property (p_sw_busy)
        else $error("switch closed while idle");
    property p_sw_pair;
        sw_first_closed == sw_second_closed;
    endproperty
    a_sw_pair: assert property (p_sw_pair)
        else $error("switches out of step");
    property p_gnd;
        first_sel_b |-> !second_sel;
    endproperty
    a_gnd: assert property (p_gnd)
        else $error("second capacitor not on ground");
    property p_start;
        go_wr && !busy |-> ##[1:3] busy;
    endproperty
    a_start: assert property (p_start)
        else $error("start not taken");
    property p_abort;
        stop_wr && sw_first_closed |-> ##[1:3] !busy;
    endproperty
    a_abort: assert property (p_abort)
        else $error("busy kept after abort");
    property p_hold;
        conv_q && busy && !sw_first_closed
            |-> $stable(first_sel_b) && $stable(osc_low_power);
    endproperty
    a_hold: assert property (p_hold)
        else $error("setting changed mid conversion");
    property p_stat;
        rd && addr == ADDR_SEQ_STATUS |=> rdata[BUSY_BIT] == $past(busy);
    endproperty
    a_stat: assert property (p_stat)
        else $error("status busy bit wrong");
    c_conv: cover property ($rose(sw_first_closed));
    c_ch1: cover property (sw_first_closed && first_sel_b);
    c_abort: cover property (stop_wr && sw_first_closed);
endmodule
bind safc_top safc_top_checker safc_top_checker_inst (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .hso_tick(hso_tick), .lpo_tick(lpo_tick),
    .sar_code(sar_code), .sw_first_closed(sw_first_closed),
    .sw_second_closed(sw_second_closed), .first_sel_b(first_sel_b),
    .second_sel(second_sel), .osc_low_power(osc_low_power),
    .busy(busy), .result(result));

//--- test/tb.sv
`timescale 1ns/100ps
module tb;
    import safc_pkg::*;
    logic clk, rstn, wr, rd, hso_tick, lpo_tick, busy, osc_low_power;
    logic sw_first_closed, sw_second_closed, first_sel_b, second_sel;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, result;
    logic [11:0] sar_code, ain_a, ain_b, offs;
    int num_errors = 0;
    int num_checks = 0;
    safc_top safc_top_inst (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .hso_tick(hso_tick), .lpo_tick(lpo_tick), .sar_code(sar_code),
        .sw_first_closed(sw_first_closed),
        .sw_second_closed(sw_second_closed), .first_sel_b(first_sel_b),
        .second_sel(second_sel), .osc_low_power(osc_low_power),
        .busy(busy), .result(result));
    safc_analog_model safc_analog_model_inst (.clk(clk), .ain_a(ain_a),
        .ain_b(ain_b), .offs(offs), .sw_first_closed(sw_first_closed),
        .first_sel_b(first_sel_b), .second_sel(second_sel), .busy(busy),
        .hso_tick(hso_tick), .lpo_tick(lpo_tick), .sar_code(sar_code));
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(logic [7:0] a, logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(logic [7:0] a, logic [15:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        check(rdata, exp);
    endtask
    task automatic wait_idle(output int n);
        for (n = 0; n < 4000 && busy !== 1'b0; n++) @(posedge clk);
    endtask
    task automatic conv(output int n);
        wreg(ADDR_SEQ_START, 16'h0001);
        @(posedge clk);
        wait_idle(n);
    endtask
    task automatic next_ch(logic exp);
        int i;
        for (i = 0; i < 400 && sw_first_closed === 1'b1; i++) @(posedge clk);
        for (i = 0; i < 400 && sw_first_closed !== 1'b1; i++) @(posedge clk);
        check({sw_first_closed, first_sel_b}, {1'b1, exp});
    endtask
    task automatic t_reset();
        int n;
        repeat (3) @(posedge clk);
        check(busy, 1'b1);
        wait_idle(n);
        rchk(ADDR_INPUT_CFG, 16'h0000);
        rchk(ADDR_OPMODE, 16'h0000);
        rchk(ADDR_OSC, 16'h0000);
        rchk(ADDR_CLOCKS_PER_CONVERSION, 16'h0015);
        rchk(ADDR_CAL_OFFSET, 16'h0023);
        rchk(8'h3f, 16'h0000);
        wreg(ADDR_CLOCKS_PER_CONVERSION, 16'h0004);
    endtask
    task automatic t_mux();
        int n;
        logic single;
        ain_a <= 12'h300;
        ain_b <= 12'h010;
        for (int i = 0; i < 4; i++) begin
            single = (i == 1 || i == 2);
            wreg(ADDR_INPUT_CFG, 16'(i));
            wreg(ADDR_SEQ_CHEN, 16'h0003);
            rchk(ADDR_SEQ_STATUS, {15'h0, single});
            wreg(ADDR_SEQ_CHEN, 16'h0001);
            conv(n);
            check(second_sel, single);
            check(first_sel_b, 1'b0);
            check(result, single ? 16'h02f0 : 16'h0300);
        end
        wreg(ADDR_INPUT_CFG, 16'h0000);
    endtask
    task automatic t_codes();
        int n;
        logic [11:0] lv [3] = '{12'h000, 12'h800, 12'hfff};
        offs <= 12'h000;
        wreg(ADDR_OFFCAL, 16'h0001);
        @(posedge clk);
        check(busy, 1'b1);
        wait_idle(n);
        for (int i = 0; i < 3; i++) begin
            ain_a <= lv[i];
            conv(n);
            check(result, {4'h0, lv[i]});
        end
    endtask
    task automatic t_seq();
        int n;
        wreg(ADDR_SEQ_CHEN, 16'h0003);
        for (int m = 4; m < 8; m++) begin
            wreg(ADDR_OPMODE, 16'(m));
            wreg(ADDR_SEQ_START, 16'h0001);
            next_ch(1'b0);
            if (m > 5)
                next_ch(1'b1);
            wreg(ADDR_SEQ_START, 16'h0002);
            wait_idle(n);
            check(n < 8, 1'b1);
        end
        wreg(ADDR_OPMODE, 16'h0006);
        wreg(ADDR_SEQ_CHEN, 16'h0002);
        wreg(ADDR_SEQ_START, 16'h0001);
        next_ch(1'b1);
        next_ch(1'b1);
        wreg(ADDR_SEQ_START, 16'h0002);
        wait_idle(n);
    endtask
    task automatic t_hp_osc();
        int n;
        ain_a <= 12'h100;
        wreg(ADDR_OPMODE, 16'h0007);
        wreg(ADDR_SEQ_CHEN, 16'h0001);
        conv(n);
        check(result, 16'h1000);
        wreg(ADDR_OPMODE, 16'h0000);
        wreg(ADDR_CLOCKS_PER_CONVERSION, 16'h0008);
        wreg(ADDR_OSC, 16'h0001);
        check(osc_low_power, 1'b0);
        conv(n);
        check(osc_low_power, 1'b1);
        check(n >= 100 && n <= 160, 1'b1);
        wreg(ADDR_OSC, 16'h0000);
        conv(n);
        check(osc_low_power, 1'b0);
        check(n >= 24 && n <= 52, 1'b1);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run needs well under 10000 cycles
    initial begin
        #200us;
        num_errors++;
        finish_test();
    end
    initial begin
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        rstn = 1'b0;
        ain_a = 12'h000;
        ain_b = 12'h000;
        offs = 12'h023;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_mux();
        t_codes();
        t_seq();
        t_hp_osc();
        finish_test();
    end
endmodule
